// ### hss_device.sv
/*
  Standby control device: mode pin filter and reset, clock-stop gating,
  halt state with its release mask, key input latches.
  Assumes all link inputs are synchronous to sys_clk; power-on reset is srst.
*/
// How it works
// RQ1: Clock-stop operand is always all zeros.
// RQ2: Clock-stop stops oscillator only when pin low.
// RQ3: Clock-stop with pin high acts as no-op.
// RQ4: Filtered pin rising edge resets the device.
// RQ5: Pin levels shorter than 187.5 us ignored.
// RQ6: Filtered pin level readable at address 07H.
// RQ7: Halt stops CPU clock, program counter held.
// RQ8: Halt works whatever the mode pin level.
// RQ9: Peripherals keep running while CPU halted.
// RQ10: Four-bit mask; any enabled condition releases halt.
// RQ11: Mask release resumes at next instruction.
// RQ12: Power-on or pin reset ends halt, resets.
// RQ13: All-zero mask: only resets end halt.
// RQ14: Key mask bit: any high key releases.
// RQ15: Timer mask bit: carry set releases halt.
// RQ16: Undefined mask bit kept zero by software.
// RQ17: Interrupt mask bit: accepted interrupt releases halt.
// RQ18: Key inputs pulled down internally.
// RQ19: Converter-selected key pin latch holds last level.
// RQ20: Raise key source before key-entry halt.
// RQ21: Selected converter pin latch low before halt.
// RQ22: Mask 0010B timer carry, 1000B interrupt.
// RQ23: Interrupt release vectors, returns after halt.
// RQ24: Release checked each cycle, CPU restarts next.
`timescale 1ns/10ps
module hss_device
#(
  parameter int CE_FILT_CYC = hss_pkg::CE_FILT_CYC
)
(
  hss_if.dev   link,
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic timerCarry,
  input  wire logic intAccept,
  output logic      chipReset,
  output logic      haltIntWake,
  output logic      periphRun,
  output logic [3:0] keyLatch,
  output logic      ceFlag
);
  localparam int CW = $clog2(CE_FILT_CYC + 1);
  localparam logic [CW-1:0] FILT_LAST = CW'(CE_FILT_CYC - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ST_RUN  = 3'b001,
    ST_HALT = 3'b010,
    ST_STOP = 3'b100
  } hss_dev_state_t;

  typedef struct packed
  {
    hss_dev_state_t st;
    logic [3:0]     mask;
    logic           filt;
    logic [CW-1:0]  cnt;
    logic [3:0]     latch;
    logic           rst;
    logic           intWake;
    logic [3:0]     rdata;
  } hss_dev_s_t;

  hss_dev_s_t s_reg;
  hss_dev_s_t s_next;

  logic [3:0] pinLevel;
  logic [3:0] selMask;
  logic       relHit;
  logic       ceRise;

  // Undriven key pins read low, like a pull-down resistor.
  assign pinLevel = link.keyOut & link.keyOe; // RQ18
  assign selMask  = link.adcSelEn ? (4'h1 << link.adcSelIdx) : 4'h0;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next         = s_reg;
    s_next.rst     = 1'b0;
    s_next.intWake = 1'b0;
    ceRise         = 1'b0;

    // A level change is taken only after it has stood a full window.
    if (link.ceDrive == s_reg.filt)
    begin
      s_next.cnt = '0;
    end
    else if (s_reg.cnt == FILT_LAST)
    begin
      s_next.cnt  = '0;
      s_next.filt = link.ceDrive; // RQ5
      ceRise      = link.ceDrive; // RQ4
    end
    else
    begin
      s_next.cnt = s_reg.cnt + CW'(1);
    end

    // The converter-selected pin is cut off; its latch keeps its level.
    s_next.latch = (pinLevel & ~selMask) | (s_reg.latch & selMask); // RQ19

    // The reserved bit is not decoded, so a stray one has no effect.
    relHit  = (s_reg.mask[hss_pkg::MASK_KEY] & (|s_reg.latch)) // RQ14
            | (s_reg.mask[hss_pkg::MASK_TMR] & timerCarry)      // RQ15 RQ22
            | (s_reg.mask[hss_pkg::MASK_INT] & intAccept);      // RQ17 RQ22

    case (s_reg.st)
      ST_RUN:
      begin
        if (link.instrValid && link.instrOp == hss_pkg::HSS_OP_HALT)
        begin
          s_next.st   = ST_HALT; // RQ7 RQ8
          s_next.mask = link.instrArg;
        end
        else if (link.instrValid && link.instrOp == hss_pkg::HSS_OP_STOP)
        begin
          if (!s_reg.filt)
          begin
            s_next.st = ST_STOP; // RQ2
          end
        end
      end
      ST_HALT:
      begin
        // A zero mask never releases; only a reset gets out.
        if (relHit) // RQ10 RQ13 RQ24
        begin
          s_next.st      = ST_RUN; // RQ11
          s_next.mask    = hss_pkg::MASK_NONE;
          s_next.intWake = s_reg.mask[hss_pkg::MASK_INT] & intAccept; // RQ23
        end
      end
      ST_STOP:
      begin
        s_next.st = ST_STOP;
      end
      default:
      begin
        s_next.st = ST_RUN;
      end
    endcase

    if (ceRise)
    begin
      s_next.st   = ST_RUN; // RQ12
      s_next.mask = hss_pkg::MASK_NONE;
      s_next.rst  = 1'b1; // RQ4
    end

    s_next.rdata = '0;
    if (link.regAddr == hss_pkg::CE_REG_ADDR)
    begin
      s_next.rdata[hss_pkg::CE_FLAG_BIT] = s_reg.filt; // RQ6
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s_reg.st      <= ST_RUN; // RQ12
      s_reg.mask    <= hss_pkg::MASK_NONE;
      s_reg.filt    <= 1'b0;
      s_reg.cnt     <= '0;
      s_reg.latch   <= 4'h0;
      s_reg.rst     <= 1'b0;
      s_reg.intWake <= 1'b0;
      s_reg.rdata   <= 4'h0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Instructions are taken only while the CPU runs; a clock-stop with the
  // pin high is taken and dropped, so the CPU simply moves on.
  assign link.instrAccept = link.instrValid && (s_reg.st == ST_RUN); // RQ3
  assign link.cpuRun      = (s_reg.st == ST_RUN); // RQ7
  assign link.oscRun      = (s_reg.st != ST_STOP);
  assign link.regRdata    = s_reg.rdata;
  // Peripherals only stop with the oscillator, never with the halt.
  assign periphRun        = (s_reg.st != ST_STOP); // RQ9
  assign chipReset        = s_reg.rst;
  assign haltIntWake      = s_reg.intWake;
  assign keyLatch         = s_reg.latch;
  assign ceFlag           = s_reg.filt;
endmodule

// ### hss_host.sv
/*
  Controller end: takes orders over AHB-Lite, drives the mode pin, the key
  source and converter select, and issues halt and clock-stop instructions.
  Assumes one AHB-Lite master, word transfers only, same sys_clk as the link.
*/
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module hss_host
(
  hss_if.host         link,
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [3:0]  keyClosed,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    HS_IDLE  = 3'b001,
    HS_PREP  = 3'b010,
    HS_ISSUE = 3'b100
  } hss_host_state_t;

  typedef struct packed
  {
    hss_host_state_t st;
    logic        ce;
    logic        adcEn;
    logic [1:0]  adcIdx;
    logic        keySrc;
    logic [1:0]  op;
    logic [3:0]  arg;
    logic        wrPend;
    logic [7:0]  addr;
    logic [31:0] rdata;
  } hss_host_s_t;

  hss_host_s_t s_reg;
  hss_host_s_t s_next;
  logic        addrPhase;
  logic [3:0]  mask;
  logic        keySrcNow;

  assign addrPhase = hsel && htrans[1] && hready;
  // The reserved release bit is forced low whatever software writes.
  assign mask = hwdata[hss_pkg::CMD_MASKLO +: 4] & ~(4'h1 << hss_pkg::MASK_RSV); // RQ16

  always_comb
  begin
    s_next        = s_reg;
    s_next.wrPend = 1'b0;

    if (s_reg.wrPend && s_reg.addr == hss_pkg::OFS_CTRL)
    begin
      s_next.ce     = hwdata[hss_pkg::CTRL_CE];
      s_next.adcEn  = hwdata[hss_pkg::CTRL_ADCEN];
      s_next.adcIdx = hwdata[hss_pkg::CTRL_ADCLO +: 2];
      s_next.keySrc = hwdata[hss_pkg::CTRL_KEYSRC];
    end

    case (s_reg.st)
      HS_IDLE:
      begin
        // Commands written while busy are dropped.
        if (s_reg.wrPend && s_reg.addr == hss_pkg::OFS_CMD)
        begin
          if (hwdata[hss_pkg::CMD_HALT])
          begin
            s_next.op  = hss_pkg::HSS_OP_HALT;
            s_next.arg = mask;
            // A key halt first parks the source low for one cycle so that
            // every latch, the converter one included, settles low.
            s_next.st  = mask[hss_pkg::MASK_KEY] ? HS_PREP : HS_ISSUE; // RQ21
          end
          else if (hwdata[hss_pkg::CMD_STOP])
          begin
            s_next.op  = hss_pkg::HSS_OP_STOP;
            s_next.arg = hss_pkg::STOP_ARG; // RQ1
            s_next.st  = HS_ISSUE;
          end
        end
      end
      HS_PREP:
      begin
        s_next.keySrc = 1'b1; // RQ20
        s_next.st     = HS_ISSUE;
      end
      HS_ISSUE:
      begin
        if (link.instrAccept)
        begin
          s_next.st = HS_IDLE;
        end
      end
      default:
      begin
        s_next.st = HS_IDLE;
      end
    endcase

    if (addrPhase)
    begin
      s_next.wrPend = hwrite;
      s_next.addr   = haddr[7:0];
      s_next.rdata  = '0;
      case (haddr[7:0])
        hss_pkg::OFS_CTRL:
        begin
          s_next.rdata[hss_pkg::CTRL_CE]          = s_reg.ce;
          s_next.rdata[hss_pkg::CTRL_ADCEN]       = s_reg.adcEn;
          s_next.rdata[hss_pkg::CTRL_ADCLO +: 2]  = s_reg.adcIdx;
          s_next.rdata[hss_pkg::CTRL_KEYSRC]      = s_reg.keySrc;
        end
        hss_pkg::OFS_STATUS:
        begin
          s_next.rdata[hss_pkg::ST_CEFLAG] = link.regRdata[hss_pkg::CE_FLAG_BIT];
          s_next.rdata[hss_pkg::ST_CPURUN] = link.cpuRun;
          s_next.rdata[hss_pkg::ST_OSCRUN] = link.oscRun;
          s_next.rdata[hss_pkg::ST_BUSY]   = (s_reg.st != HS_IDLE);
        end
        default:
        begin
          s_next.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s_reg.st     <= HS_IDLE;
      s_reg.ce     <= 1'b0;
      s_reg.adcEn  <= 1'b0;
      s_reg.adcIdx <= 2'h0;
      s_reg.keySrc <= 1'b0;
      s_reg.op     <= 2'h0;
      s_reg.arg    <= 4'h0;
      s_reg.wrPend <= 1'b0;
      s_reg.addr   <= 8'h00;
      s_reg.rdata  <= 32'h0000_0000;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign keySrcNow      = s_reg.keySrc && (s_reg.st != HS_PREP);
  assign link.keyOut    = keyClosed & {4{keySrcNow}};
  assign link.keyOe     = keyClosed & {4{keySrcNow}};
  assign link.adcSelEn  = s_reg.adcEn && (s_reg.st != HS_PREP);
  assign link.adcSelIdx = s_reg.adcIdx;
  assign link.ceDrive   = s_reg.ce;
  assign link.regAddr   = hss_pkg::CE_REG_ADDR;
  assign link.instrValid = (s_reg.st == HS_ISSUE);
  assign link.instrOp   = s_reg.op;
  assign link.instrArg  = s_reg.arg;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign hrdata         = s_reg.rdata;
endmodule

// ### hss_if.sv
/*
  Link between the standby control device and its controller.
  Assumes both ends run on the same sys_clk.
*/
`timescale 1ns/10ps
interface hss_if
(
  input wire logic sys_clk
);
  logic       instrValid;
  logic [1:0] instrOp;
  logic [3:0] instrArg;
  logic       instrAccept;
  logic       ceDrive;
  logic [3:0] keyOut;
  logic [3:0] keyOe;
  logic       adcSelEn;
  logic [1:0] adcSelIdx;
  logic [5:0] regAddr;
  logic [3:0] regRdata;
  logic       cpuRun;
  logic       oscRun;

  modport dev
  (
    input  instrValid, instrOp, instrArg, ceDrive, keyOut, keyOe,
    input  adcSelEn, adcSelIdx, regAddr,
    output instrAccept, regRdata, cpuRun, oscRun
  );
  modport host
  (
    output instrValid, instrOp, instrArg, ceDrive, keyOut, keyOe,
    output adcSelEn, adcSelIdx, regAddr,
    input  instrAccept, regRdata, cpuRun, oscRun
  );
endinterface

// ### hss_pkg.sv
/*
  Shared constants and types for the halt and clock-stop standby control.
  Assumes a 50 MHz system clock and a synchronous, active high reset.
*/
package hss_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam real CLK_MHZ     = 50.0;
  localparam real CE_FILT_US  = 187.5;
  localparam int  CE_FILT_CYC = int'($ceil(CE_FILT_US * CLK_MHZ));

  // ----------------------------------------------------------------
  // Instruction operands
  // ----------------------------------------------------------------
  localparam int        MASK_KEY  = 0;
  localparam int        MASK_TMR  = 1;
  localparam int        MASK_RSV  = 2;
  localparam int        MASK_INT  = 3;
  localparam logic[3:0] STOP_ARG  = 4'h0;
  localparam logic[3:0] MASK_NONE = 4'h0;

  typedef enum logic [1:0]
  {
    HSS_OP_HALT = 2'h1,
    HSS_OP_STOP = 2'h2
  } hss_op_t;

  // ----------------------------------------------------------------
  // Device control register holding the mode pin flag
  // ----------------------------------------------------------------
  localparam logic [5:0] CE_REG_ADDR = 6'h07;
  localparam int         CE_FLAG_BIT = 0;

  // ----------------------------------------------------------------
  // Controller registers on the AHB-Lite port
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam int CTRL_CE     = 0;
  localparam int CTRL_ADCEN  = 1;
  localparam int CTRL_ADCLO  = 2;
  localparam int CTRL_KEYSRC = 4;
  localparam int CMD_HALT    = 0;
  localparam int CMD_STOP    = 1;
  localparam int CMD_MASKLO  = 8;
  localparam int ST_CEFLAG   = 0;
  localparam int ST_CPURUN   = 1;
  localparam int ST_OSCRUN   = 2;
  localparam int ST_BUSY     = 3;
endpackage

// ### hss_properties.sv
/*
  Checker for the link between the standby control device and its controller.
  Assumes it sits beside the hss_if instance, on the same sys_clk and srst.
*/
`timescale 1ns/10ps
module hss_properties
#(
  parameter int CE_FILT_CYC = 8
)
(
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic       instrValid,
  input wire logic [1:0] instrOp,
  input wire logic [3:0] instrArg,
  input wire logic       instrAccept,
  input wire logic       ceDrive,
  input wire logic [3:0] regRdata,
  input wire logic       cpuRun,
  input wire logic       oscRun
);
  // ----------------------------------------------------------------
  // Helper logic and sequences
  // ----------------------------------------------------------------
  logic [15:0] ceRun_reg;
  logic        ceLast_reg;

  // Counts how long the raw mode pin has held still; saturates.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ceRun_reg  <= 16'h0;
      ceLast_reg <= 1'b0;
    end
    else
    begin
      ceLast_reg <= ceDrive;
      if (ceDrive != ceLast_reg)
        ceRun_reg <= 16'h0;
      else if (ceRun_reg != 16'hffff)
        ceRun_reg <= ceRun_reg + 16'h1;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  sequence haltTaken;
    instrValid && instrAccept && instrOp == hss_pkg::HSS_OP_HALT;
  endsequence
  sequence stopTaken;
    instrValid && instrAccept && instrOp == hss_pkg::HSS_OP_STOP;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  halt_stops_a: assert property (haltTaken |=> !cpuRun)
    else $error("cpu still clocked after an accepted halt");
  stop_gate_a: assert property ($fell(oscRun) |->
    $past(instrValid && instrAccept && instrOp == hss_pkg::HSS_OP_STOP))
    else $error("oscillator stopped without an accepted clock stop");
  stop_nop_a: assert property (stopTaken ##0 (ceDrive && $past(ceDrive) && regRdata[0])
    |=> oscRun)
    else $error("clock stop took effect with the mode pin high");
  refuse_busy_a: assert property (!cpuRun || !oscRun |-> !instrAccept)
    else $error("instruction accepted while halted or stopped");
  accept_valid_a: assert property (instrAccept |-> instrValid)
    else $error("accept without a pending instruction");
  request_hold_a: assert property (instrValid && !instrAccept
    |=> instrValid && $stable(instrOp) && $stable(instrArg))
    else $error("pending instruction changed before acceptance");
  stop_arg_a: assert property (instrValid && instrOp == hss_pkg::HSS_OP_STOP
    |-> instrArg == hss_pkg::STOP_ARG)
    else $error("clock stop operand not all zeros");
  rsv_bit_a: assert property (instrValid && instrOp == hss_pkg::HSS_OP_HALT
    |-> !instrArg[hss_pkg::MASK_RSV])
    else $error("undefined release mask bit set");
  ce_filter_a: assert property ($changed(regRdata[0])
    |-> $past(ceDrive) == regRdata[0] && $past(ceRun_reg, 2) >= CE_FILT_CYC / 2)
    else $error("mode flag changed without a long enough pin level");
endmodule

// ### tb_halt_stop_standby_control.sv
/*
  Testbench joining the controller and the device through hss_if.
  Assumes the AHB-Lite slave answers with no wait states but waits anyway.
*/
`timescale 1ns/10ps
module tb_halt_stop_standby_control;
  typedef struct packed
  {
    logic [3:0] mask;
    logic       tc;
    logic       ia;
    logic [3:0] kc;
    logic       ce;
    logic       rel;
    logic       wake;
  } hss_row_t;

  logic        sys_clk, srst, hsel, hwrite, hreadyout, hresp;
  logic        timerCarry, intAccept, chipReset, haltIntWake, periphRun, ceFlag, seen;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  keyClosed, keyLatch;
  int          errors, nCompared;
  hss_row_t    rows [9] = '{
    {4'h2, 1'b1, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0},
    {4'h1, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0, 1'b0},
    {4'h8, 1'b0, 1'b1, 4'h0, 1'b0, 1'b1, 1'b1},
    {4'h1, 1'b0, 1'b0, 4'h8, 1'b0, 1'b1, 1'b0},
    {4'h0, 1'b1, 1'b1, 4'hf, 1'b0, 1'b0, 1'b0},
    {4'h2, 1'b0, 1'b1, 4'hf, 1'b0, 1'b0, 1'b0},
    {4'hb, 1'b1, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0},
    {4'h4, 1'b1, 1'b1, 4'hf, 1'b0, 1'b0, 1'b0},
    {4'h2, 1'b1, 1'b0, 4'h0, 1'b1, 1'b1, 1'b0}};

  hss_if link(.sys_clk(sys_clk));
  hss_host i_hss_host(.link(link), .sys_clk(sys_clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .keyClosed(keyClosed), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp));
  hss_device #(.CE_FILT_CYC(8)) i_hss_device(.link(link), .sys_clk(sys_clk), .srst(srst),
    .timerCarry(timerCarry), .intAccept(intAccept), .chipReset(chipReset),
    .haltIntWake(haltIntWake), .periphRun(periphRun), .keyLatch(keyLatch), .ceFlag(ceFlag));
  hss_properties #(.CE_FILT_CYC(8)) i_hss_properties(.sys_clk(sys_clk), .srst(srst),
    .instrValid(link.instrValid), .instrOp(link.instrOp), .instrArg(link.instrArg),
    .instrAccept(link.instrAccept), .ceDrive(link.ceDrive), .regRdata(link.regRdata),
    .cpuRun(link.cpuRun), .oscRun(link.oscRun));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test;
    if (errors == 0 && nCompared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  function automatic logic pick(input int s);
    return s == 0 ? hreadyout : (s == 1 ? link.cpuRun : link.oscRun);
  endfunction

  // Bounded wait; running out of cycles ends the run as a failure.
  task automatic wait_on(input int s, input logic v);
    int k;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pick(s) !== v && k < 100);
    if (k >= 100)
    begin
      errors++;
      finish_test();
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_on(0, 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_on(0, 1'b1);
    rd = hrdata;
  endtask

  task automatic watch_reset(input int n);
    seen = 1'b0;
    repeat (n)
    begin
      @(posedge sys_clk);
      seen = seen | chipReset;
    end
  endtask

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (50000) @(posedge sys_clk);
    errors++;
    finish_test();
  end

  initial
  begin
    {srst, hsel, hwrite, timerCarry, intAccept} = 5'h10;
    {haddr, hwdata, htrans, keyClosed} = '0;
    hsize = 3'h2;
    errors = 0;
    nCompared = 0;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    ahb(1'b0, hss_pkg::OFS_STATUS, 32'h0);
    check("status", rd[3:0], 4'h6);
    foreach (rows[i])
    begin
      ahb(1'b1, hss_pkg::OFS_CTRL, {31'h0, rows[i].ce});
      repeat (12) @(posedge sys_clk);
      ahb(1'b1, hss_pkg::OFS_CMD, {20'h0, rows[i].mask, 8'h01});
      wait_on(1, 1'b0);
      check("periph", periphRun, 1'b1);
      timerCarry <= rows[i].tc;
      intAccept <= rows[i].ia;
      keyClosed <= rows[i].kc;
      seen = 1'b0;
      repeat (4)
      begin
        @(posedge sys_clk);
        seen = seen | haltIntWake;
      end
      check("release", link.cpuRun, rows[i].rel);
      check("wake", seen, rows[i].wake);
      {timerCarry, intAccept, keyClosed} <= '0;
      if (!rows[i].rel)
      begin
        // A clock stop issued while halted must stay pending and change nothing.
        ahb(1'b1, hss_pkg::OFS_CMD, 32'h2);
        repeat (3) @(posedge sys_clk);
        check("refused", {link.cpuRun, link.oscRun}, 2'b01);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        wait_on(1, 1'b1);
      end
    end
    // Clock stop with the mode pin high must leave everything running.
    ahb(1'b1, hss_pkg::OFS_CMD, 32'h2);
    repeat (6) @(posedge sys_clk);
    check("osc_nop", link.oscRun & link.cpuRun, 1'b1);
    ahb(1'b1, hss_pkg::OFS_CTRL, 32'h0);
    repeat (12) @(posedge sys_clk);
    ahb(1'b1, hss_pkg::OFS_CTRL, 32'h1);
    ahb(1'b1, hss_pkg::OFS_CTRL, 32'h0);
    watch_reset(20);
    check("glitch", seen, 1'b0);
    ahb(1'b0, hss_pkg::OFS_STATUS, 32'h0);
    check("flag_low", rd[0], 1'b0);
    ahb(1'b1, hss_pkg::OFS_CMD, 32'h2);
    wait_on(2, 1'b0);
    check("stopped", periphRun, 1'b0);
    ahb(1'b1, hss_pkg::OFS_CTRL, 32'h1);
    watch_reset(20);
    check("ce_reset", seen, 1'b1);
    check("osc_back", link.oscRun, 1'b1);
    ahb(1'b0, hss_pkg::OFS_STATUS, 32'h0);
    check("flag_high", rd[0], 1'b1);
    check("ce_flag", ceFlag, 1'b1);
    ahb(1'b1, hss_pkg::OFS_CTRL, 32'h11);
    keyClosed <= 4'h5;
    repeat (3) @(posedge sys_clk);
    check("keys", keyLatch, 4'h5);
    ahb(1'b1, hss_pkg::OFS_CTRL, 32'h13);
    keyClosed <= 4'h0;
    repeat (3) @(posedge sys_clk);
    check("key_held", keyLatch, 4'h1);
    ahb(1'b1, 8'h20, 32'hffffffff);
    ahb(1'b0, 8'h20, 32'h0);
    check("unmapped", rd, 32'h0);
    finish_test();
  end
endmodule
